// [bench/acc_cell_model.sv]
`timescale 1ns/100ps
// Behavioural analog cell: answers each start pulse after a short settle time
module acc_cell_model
   import acc_pkg::*;
(
   input wire logic clk_in, // Master clock
   input wire logic start_in, // Start pulse from controller
   input wire logic [CH_IDX_W-1:0] channel_in, // Channel to convert
   output logic done_out, // One-cycle done pulse
   output logic [RESULT_W-1:0] data_out // Result, valid with done only
);
   localparam int LAT = 3;
   int cnt = 0;
   initial done_out = 1'h0;
   initial data_out = 10'h000;
   // Outside done the data is inverted each cycle, so a stale result never passes
   always @(posedge clk_in) begin
      done_out <= 1'h0;
      data_out <= ~data_out;
      if (start_in) begin
         cnt <= LAT;
      end else if (cnt == 1) begin
         done_out <= 1'h1;
         data_out <= {channel_in, 7'h55};
      end
      if (cnt != 0 && !start_in) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// [bench/acc_converter_ctrl_chk.sv]
`timescale 1ns/100ps
// Watches the cell and result ports of the controller
module acc_converter_ctrl_chk
   import acc_pkg::*;
(
   input wire logic clk_in, // Master clock
   input wire logic rst_in, // Reset, high
   input wire logic psel, // APB select
   input wire logic penable, // APB access
   input wire logic pwrite, // APB write
   input wire logic [ADDR_W-1:0] paddr, // APB address
   input wire logic [DATA_W-1:0] pwdata, // APB write data
   input wire logic pslverr, // APB error
   input wire logic cell_power_out, // Cell active
   input wire logic cell_sample_out, // Sample phase
   input wire logic cell_start_out, // Start pulse
   input wire logic [CH_IDX_W-1:0] cell_channel_out, // Channel
   input wire logic cell_low_res_out, // Eight-bit mode
   input wire logic cell_done_in, // Cell done
   input wire logic [RESULT_W-1:0] cell_data_in, // Cell result
   input wire logic result_valid_out, // Result pulse
   input wire logic [RESULT_W-1:0] result_data_out // Result value
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   logic soft_rst;
   // Soft reset clears the result without a valid pulse, so the hold check skips it
   assign soft_rst = psel && penable && pwrite && paddr == OFS_CONVERTER_COMMAND && pwdata[CMD_SOFT_RESET_BIT];
   a_start_single: assert property (cell_start_out |=> !cell_start_out)
      else $error("start pulse too long");
   a_sample_first: assert property (cell_start_out |-> $past(cell_sample_out))
      else $error("start without sample phase");
   a_chan_hold: assert property (cell_sample_out && $past(cell_sample_out) |-> $stable(cell_channel_out))
      else $error("channel moved during sample");
   a_power_start: assert property (cell_start_out |-> cell_power_out)
      else $error("start while cell off");
   a_done_result: assert property (cell_done_in |=> result_valid_out)
      else $error("no result after done");
   a_full_value: assert property (result_valid_out && !cell_low_res_out |-> result_data_out == $past(cell_data_in))
      else $error("wrong ten-bit result");
   a_low_value: assert property (result_valid_out && cell_low_res_out |->
      result_data_out == {2'h0, $past(cell_data_in[9:2])})
      else $error("wrong eight-bit result");
   a_result_hold: assert property (!result_valid_out && !$past(soft_rst) |-> $stable(result_data_out))
      else $error("result changed without new data");
   a_valid_single: assert property (result_valid_out |=> !result_valid_out)
      else $error("result pulse too long");
   c_low_res: cover property (result_valid_out && cell_low_res_out);
   c_start: cover property ($rose(cell_start_out));
   c_slverr: cover property (pslverr);
endmodule

bind acc_converter_ctrl acc_converter_ctrl_chk u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .cell_power_out(cell_power_out),
   .cell_sample_out(cell_sample_out), .cell_start_out(cell_start_out), .cell_channel_out(cell_channel_out),
   .cell_low_res_out(cell_low_res_out), .cell_done_in(cell_done_in), .cell_data_in(cell_data_in),
   .result_valid_out(result_valid_out), .result_data_out(result_data_out)
);

// [bench/acc_converter_ctrl_tb.sv]
`timescale 1ns/100ps
module acc_converter_ctrl_tb
   import acc_pkg::*;
;
   localparam logic [31:0] M = 32'h01000100;
   logic clk_in = 1'h0, rst_in = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [DATA_W-1:0] pwdata = 32'h00000000, prdata, q;
   logic [2:0] trg = 3'h0;
   logic [NUM_CH-1:0] rd_ch = 8'h00;
   logic dz = 1'h1, dnz = 1'h1, dw = 1'h0, pready, pslverr, err, pwr, cclk, smp, cst, lres, done, rv, irq;
   logic [CH_IDX_W-1:0] cch, rch;
   logic [RESULT_W-1:0] cdat, rdat;
   int miscompares = 0, n_checks = 0, nres = 0;
   // Clock and result counter
   always #2 clk_in = ~clk_in;
   always @(posedge clk_in) if (rv === 1'h1) nres <= nres + 1;
   acc_converter_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer0_a_in(trg[0]), .timer1_a_in(trg[1]), .ext_trigger_in(trg[2]), .cell_power_out(pwr),
      .converter_clock_out(cclk), .cell_sample_out(smp), .cell_start_out(cst), .cell_channel_out(cch),
      .cell_low_res_out(lres), .cell_done_in(done), .cell_data_in(cdat), .result_valid_out(rv),
      .result_channel_out(rch), .result_data_out(rdat), .channel_data_read_in(rd_ch),
      .dma_rx_zero_in(dz), .dma_next_rx_zero_in(dnz), .dma_counter_write_in(dw), .irq_out(irq));
   acc_cell_model u_cell (.clk_in(clk_in), .start_in(cst), .channel_in(cch), .done_out(done), .data_out(cdat));
   // Verdict and comparison helpers
   task automatic complete_run();
      if (miscompares == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic stop();
      miscompares++;
      complete_run();
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'h1;
      i = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (pready !== 1'h1 && i < 20);
      if (i >= 20) stop();
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic wait_n(input int n);
      int i;
      for (i = 0; i < 3000 && nres < n; i++) @(posedge clk_in);
      if (nres < n) stop();
   endtask
   task automatic cc(input logic v, inout int p);
      int i;
      for (i = 0; i < 9 && cclk !== v; i++) begin
         @(posedge clk_in);
         p++;
      end
   endtask
   // Scenarios
   task automatic t_reset();
      rd(OFS_CONVERTER_MODE, 32'h0);
      rd(OFS_CHANNEL_ENABLED_STATE, 32'h0);
      rd(OFS_CONVERTER_FLAGS, FLAGS_RESET);
      rd(OFS_LATEST_RESULT, 32'h0);
      rd(8'h08, 32'h0);
      chk(err, 1'h1);
   endtask
   task automatic t_dma();
      @(posedge clk_in);
      dz <= 1'h0;
      dw <= 1'h1;
      @(posedge clk_in);
      dw <= 1'h0;
      rd(OFS_CONVERTER_FLAGS, 32'h0);
      dz <= 1'h1;
      dnz <= 1'h0;
      rd(OFS_CONVERTER_FLAGS, 32'h00040000);
      dnz <= 1'h1;
      rd(OFS_CONVERTER_FLAGS, 32'h000C0000);
   endtask
   task automatic t_chan();
      apb(1'h1, OFS_CHANNEL_ENABLE_SET, 32'hA5);
      apb(1'h1, OFS_CHANNEL_ENABLE_CLEAR, 32'h05);
      rd(OFS_CHANNEL_ENABLED_STATE, 32'hA0);
   endtask
   task automatic t_seq();
      int c, p;
      apb(1'h1, OFS_CONVERTER_MODE, M);
      apb(1'h1, OFS_CONVERTER_COMMAND, 32'h2);
      apb(1'h1, OFS_CONVERTER_COMMAND, 32'h2);
      for (c = 0; c < 100 && smp !== 1'h1; c++) @(posedge clk_in);
      chk(c >= 26 && c <= 36, 1'h1);
      for (c = 0; c < 20 && smp === 1'h1; c++) @(posedge clk_in);
      chk(c >= 7 && c <= 9, 1'h1);
      p = 0;
      cc(1'h0, p);
      cc(1'h1, p);
      p = 0;
      cc(1'h0, p);
      cc(1'h1, p);
      chk(p, 4);
      wait_n(2);
      idle(40);
      chk(nres, 2);
      rd(OFS_CONVERTER_FLAGS, 32'h000D00A0);
      rd(OFS_LATEST_RESULT, 32'h3D5);
      chk(rch, 3'h7);
      rd(OFS_CONVERTER_FLAGS, 32'h000C00A0);
   endtask
   task automatic t_ovr();
      apb(1'h1, OFS_CONVERTER_COMMAND, 32'h2);
      wait_n(4);
      rd(OFS_CONVERTER_FLAGS, 32'h000FA0A0);
      rd(OFS_CONVERTER_FLAGS, 32'h000D00A0);
      rd_ch <= 8'h80;
      @(posedge clk_in);
      rd_ch <= 8'h00;
      apb(1'h1, OFS_CHANNEL_ENABLE_CLEAR, 32'h20);
      rd(OFS_CONVERTER_FLAGS, 32'h000D0000);
   endtask
   task automatic t_trig();
      logic [3:0] md[6] = '{4'hD, 4'h3, 4'h1, 4'h3, 4'h5, 4'hC};
      int src[6] = '{2, 0, 0, 1, 2, 2};
      int ex[6] = '{1, 0, 1, 1, 0, 0};
      int k, n;
      for (k = 0; k < 6; k++) begin
         apb(1'h1, OFS_CONVERTER_MODE, M | md[k]);
         n = nres;
         trg[src[k]] <= 1'h1;
         idle(2);
         trg[src[k]] <= 1'h0;
         idle(60);
         chk(nres, n + ex[k]);
      end
      apb(1'h1, OFS_CONVERTER_MODE, M | 32'hD);
      apb(1'h1, OFS_CONVERTER_COMMAND, 32'h2);
      wait_n(n + 1);
   endtask
   task automatic t_low_sleep();
      apb(1'h1, OFS_CONVERTER_MODE, M | 32'h30);
      apb(1'h1, OFS_CONVERTER_COMMAND, 32'h2);
      wait_n(nres + 1);
      idle(8);
      chk(pwr, 1'h0);
      chk(lres, 1'h1);
      rd(OFS_LATEST_RESULT, 32'hF5);
   endtask
   task automatic t_irq();
      apb(1'h1, OFS_CONVERTER_MODE, M);
      apb(1'h1, OFS_IRQ_ENABLE_SET, 32'h10000);
      apb(1'h1, OFS_CONVERTER_COMMAND, 32'h2);
      chk(irq, 1'h0);
      wait_n(nres + 1);
      idle(2);
      chk(irq, 1'h1);
      rd(OFS_IRQ_ENABLED_STATE, 32'h10000);
      apb(1'h1, OFS_IRQ_ENABLE_CLEAR, 32'h10000);
      idle(1);
      chk(irq, 1'h0);
      apb(1'h1, OFS_IRQ_ENABLE_SET, 32'h10000);
      rd(OFS_LATEST_RESULT, 32'h3D5);
      idle(1);
      chk(irq, 1'h0);
   endtask
   task automatic t_soft();
      apb(1'h1, OFS_CONVERTER_COMMAND, 32'h1);
      rd(OFS_CONVERTER_MODE, 32'h0);
      rd(OFS_CHANNEL_ENABLED_STATE, 32'h0);
      rd(OFS_IRQ_ENABLED_STATE, 32'h0);
      rd(OFS_CONVERTER_FLAGS, FLAGS_RESET);
   endtask
   // Main sequence
   initial begin
      idle(6);
      rst_in <= 1'h0;
      t_reset();
      t_dma();
      t_chan();
      t_seq();
      t_ovr();
      t_trig();
      t_low_sleep();
      t_irq();
      t_soft();
      complete_run();
   end
endmodule

// [logic/acc_clock_divider.sv]
`timescale 1ns/100ps
module acc_clock_divider
   import acc_pkg::*;
(
   input wire logic clk_in, // Master clock
   input wire logic rst_in, // Synchronous reset, high
   input wire logic run_in, // Divider runs while high
   input wire logic [CLOCK_DIVIDER_W-1:0] divider_in, // Prescaler field
   output logic tick_out, // One-cycle pulse per converter clock period
   output logic converter_clock_out // Converter clock to the analog cell
);

   typedef struct packed {
      logic [CLOCK_DIVIDER_W-1:0] count;
      logic phase;
      logic tick;
   } acc_div_s;

   acc_div_s s;
   acc_div_s next_s;

   // Half period is divider+1 master cycles, so a full period is twice that [R6]
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!run_in) begin
         next_s = '0; // Stopped clock restarts from a known phase
      end else if (s.count == divider_in) begin
         next_s.count = '0;
         next_s.phase = ~s.phase;
         next_s.tick = ~s.phase; // [R6]
      end else begin
         next_s.count = s.count + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick_out = s.tick;
   assign converter_clock_out = s.phase;

endmodule

// [logic/acc_converter_ctrl.sv]
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
// Overview of operation
// R1: Writing one to soft reset returns the whole controller to reset state.
// R2: Writing one to start launches a sequence on enabled channels.
// R3: Hardware trigger off: only the software start command begins conversions.
// R4: Hardware trigger on: the source chosen by the selection field starts conversions.
// R5: Codes 000 timer 0 output A, 001 timer 1 output A, 110 external pin.
// R6: Converter clock is master clock over twice (divider field plus one).
// R7: After activation wait eight times (startup field plus one) converter periods.
// R8: Sample-and-hold lasts (sample-hold field plus one) converter periods per channel.
// R9: Ones written to the channel enable set register enable those channels.
// R10: Ones written to the channel enable clear register disable those channels.
// R11: Software must not disable or re-enable a channel during a conversion.
// R12: Channel state register shows one for each enabled channel.
// R13: Done flag reads one only when channel enabled and its conversion finished.
// R14: Per-channel overrun flags in bits 8 to 15 set on overrun, clear on read.
// R15: Result-ready flag bit 16 sets on new result, clears on result read.
// R16: Global overrun flag bit 17 sets on any overrun, clears on flag read.
// R17: Receive end flag bit 18 sets when counter reaches zero, clears on counter write.
// R18: Receive full flag bit 19 reads one when both DMA counters are zero.
// R19: Every conversion loads its result into the ten-bit latest result field.
// R20: Ones written to interrupt enable set register enable those interrupts.
// R21: Ones written to interrupt enable clear register disable those interrupts.
// R22: Hardware start is detected on each rising edge of the selected trigger.
// R23: Software start still works while a hardware trigger is enabled.
// R24: Sleep mode powers the cell per sequence, then powers it down again.
// R25: Start requests arriving during a running sequence are ignored.
// R26: Resolution bit picks ten or eight bits; sleep bit picks power-down sequencing.
// R27: Interrupt output is high while any enabled flag is set.
module acc_converter_ctrl
   import acc_pkg::*;
(
   input wire logic clk_in, // Master clock
   input wire logic rst_in, // Synchronous reset, high
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [ADDR_W-1:0] paddr, // APB byte address
   input wire logic [DATA_W-1:0] pwdata, // APB write data
   output logic [DATA_W-1:0] prdata, // APB read data, registered
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic timer0_a_in, // Timer channel 0 output A
   input wire logic timer1_a_in, // Timer channel 1 output A
   input wire logic ext_trigger_in, // External trigger pin
   output logic cell_power_out, // Analog cell active
   output logic converter_clock_out, // Converter clock to the cell
   output logic cell_sample_out, // Sample-and-hold phase in progress
   output logic cell_start_out, // One-cycle pulse starting a conversion
   output logic [CH_IDX_W-1:0] cell_channel_out, // Channel being converted
   output logic cell_low_res_out, // Eight-bit mode to the cell
   input wire logic cell_done_in, // Cell conversion finished, one-cycle pulse
   input wire logic [RESULT_W-1:0] cell_data_in, // Cell result, valid with done
   output logic result_valid_out, // One-cycle pulse with a new result
   output logic [CH_IDX_W-1:0] result_channel_out, // Channel of the new result
   output logic [RESULT_W-1:0] result_data_out, // New result, registered
   input wire logic [NUM_CH-1:0] channel_data_read_in, // Per-channel data read pulses
   input wire logic dma_rx_zero_in, // DMA receive counter is zero
   input wire logic dma_next_rx_zero_in, // DMA next receive counter is zero
   input wire logic dma_counter_write_in, // Pulse on write to either DMA counter
   output logic irq_out // Interrupt request, high
);

   typedef struct packed {
      acc_state_e state;
      logic [31:0] mode;
      logic [NUM_CH-1:0] chan_en;
      logic [FLAG_W-1:0] irq_en;
      logic [NUM_CH-1:0] done;
      logic [NUM_CH-1:0] overrun;
      logic result_ready;
      logic global_overrun;
      logic receive_end;
      logic rx_zero_prev;
      logic trig_prev;
      logic cell_on;
      logic [NUM_CH-1:0] pending;
      logic [CH_IDX_W-1:0] chan;
      logic [COUNT_W-1:0] count;
      logic [RESULT_W-1:0] last_data;
      logic [DATA_W-1:0] rdata;
      logic rd_ready_seen;
      logic res_valid;
      logic [CH_IDX_W-1:0] res_chan;
      logic [RESULT_W-1:0] res_data;
      logic start_pulse;
   } acc_regs_s;

   localparam acc_regs_s REGS_RESET = '{
      state: ACC_IDLE,
      mode: MODE_RESET,
      chan_en: CHAN_ENABLE_RESET,
      irq_en: IRQ_ENABLE_RESET,
      receive_end: FLAGS_RESET[FLAG_RECEIVE_END_BIT],
      rx_zero_prev: FLAGS_RESET[FLAG_RECEIVE_END_BIT],
      default: '0
   };

   acc_regs_s s;
   acc_regs_s next_s;
   logic tick;
   logic [FLAG_W-1:0] flags;
   logic wr_done;
   logic rd_done;
   logic setup;
   logic mapped;
   logic sel_trigger;
   logic hw_start;
   logic sw_start;
   logic [COUNT_W-1:0] startup_last;
   logic [NUM_CH-1:0] remaining;

   // Lowest enabled channel goes first
   function automatic logic [CH_IDX_W-1:0] first_channel(input logic [NUM_CH-1:0] mask);
      logic [CH_IDX_W-1:0] idx;
      idx = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (mask[i]) begin
            idx = CH_IDX_W'(i);
         end
      end
      return idx;
   endfunction

   // Converter clock divider runs only while a sequence is active
   acc_clock_divider u_divider (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .run_in(s.state != ACC_IDLE),
      .divider_in(s.mode[MODE_CLOCK_DIVIDER_LSB +: CLOCK_DIVIDER_W]),
      .tick_out(tick),
      .converter_clock_out(converter_clock_out)
   );

   // Flag register view; done bits masked by channel enable [R13]
   assign flags = {dma_rx_zero_in & dma_next_rx_zero_in, // [R18]
                   s.receive_end, s.global_overrun, s.result_ready,
                   s.overrun, s.done & s.chan_en}; // [R13]

   // Bus phase decode
   assign setup = psel & ~penable;
   assign wr_done = psel & penable & pwrite;
   assign rd_done = psel & penable & ~pwrite;
   assign mapped = (paddr == OFS_CONVERTER_COMMAND) || (paddr == OFS_CONVERTER_MODE) ||
                   (paddr == OFS_CHANNEL_ENABLE_SET) || (paddr == OFS_CHANNEL_ENABLE_CLEAR) ||
                   (paddr == OFS_CHANNEL_ENABLED_STATE) || (paddr == OFS_CONVERTER_FLAGS) ||
                   (paddr == OFS_LATEST_RESULT) || (paddr == OFS_IRQ_ENABLE_SET) ||
                   (paddr == OFS_IRQ_ENABLE_CLEAR) || (paddr == OFS_IRQ_ENABLED_STATE);

   // Trigger source multiplexer; reserved codes select nothing
   always_comb begin
      case (s.mode[MODE_TRIGGER_SOURCE_LSB +: 3])
         TRIG_TIMER0_A: sel_trigger = timer0_a_in; // [R5]
         TRIG_TIMER1_A: sel_trigger = timer1_a_in; // [R5]
         TRIG_EXTERNAL: sel_trigger = ext_trigger_in; // [R5]
         default: sel_trigger = 1'b0;
      endcase
   end

   // Start sources; software start is never masked by the hardware enable
   assign hw_start = s.mode[MODE_HW_TRIGGER_ON_BIT] & sel_trigger & ~s.trig_prev; // [R3] [R4] [R22]
   assign sw_start = wr_done & (paddr == OFS_CONVERTER_COMMAND) & pwdata[CMD_START_BIT]; // [R2] [R23]
   assign startup_last = COUNT_W'({1'b0, s.mode[MODE_STARTUP_LSB +: STARTUP_W]} + 6'h01)
                         << STARTUP_UNIT_SHIFT; // [R7]
   assign remaining = s.pending & ~(NUM_CH'(1) << s.chan);

   // Next-state logic: bus, flags, sequencer
   always_comb begin
      next_s = s;
      next_s.res_valid = 1'b0;
      next_s.start_pulse = 1'b0;
      next_s.trig_prev = sel_trigger;
      next_s.rx_zero_prev = dma_rx_zero_in;

      // Read data is captured in the setup phase so it comes from a flop
      if (setup) begin
         next_s.rd_ready_seen = s.result_ready;
         case (paddr)
            OFS_CONVERTER_MODE: next_s.rdata = s.mode;
            OFS_CHANNEL_ENABLED_STATE: next_s.rdata = {24'h000000, s.chan_en}; // [R12]
            OFS_CONVERTER_FLAGS: next_s.rdata = {12'h000, flags};
            OFS_LATEST_RESULT: next_s.rdata = {22'h000000, s.last_data};
            OFS_IRQ_ENABLED_STATE: next_s.rdata = {12'h000, s.irq_en};
            default: next_s.rdata = 32'h00000000;
         endcase
      end

      // Clearing by read only drops bits software actually saw, so a late set is kept
      if (rd_done && paddr == OFS_CONVERTER_FLAGS) begin
         next_s.overrun = s.overrun & ~s.rdata[FLAG_OVERRUN_LSB +: NUM_CH]; // [R14]
         next_s.global_overrun = s.global_overrun & ~s.rdata[FLAG_GLOBAL_OVERRUN_BIT]; // [R16]
      end
      if (rd_done && paddr == OFS_LATEST_RESULT && s.rd_ready_seen) begin
         next_s.result_ready = 1'b0; // [R15]
      end
      next_s.done = s.done & ~channel_data_read_in;

      // Receive end: clear on counter write, set on arrival at zero; set wins
      if (dma_counter_write_in) begin
         next_s.receive_end = 1'b0; // [R17]
      end
      if (dma_rx_zero_in && !s.rx_zero_prev) begin
         next_s.receive_end = 1'b1; // [R17]
      end

      // Register writes
      if (wr_done) begin
         case (paddr)
            OFS_CONVERTER_MODE: next_s.mode = pwdata & MODE_WRITABLE_MASK;
            OFS_CHANNEL_ENABLE_SET: next_s.chan_en = s.chan_en | pwdata[NUM_CH-1:0]; // [R9]
            OFS_CHANNEL_ENABLE_CLEAR: next_s.chan_en = s.chan_en & ~pwdata[NUM_CH-1:0]; // [R10]
            OFS_IRQ_ENABLE_SET: next_s.irq_en = s.irq_en | pwdata[FLAG_W-1:0]; // [R20]
            OFS_IRQ_ENABLE_CLEAR: next_s.irq_en = s.irq_en & ~pwdata[FLAG_W-1:0]; // [R21]
            default: next_s.irq_en = s.irq_en;
         endcase
      end

      // Conversion sequencer
      case (s.state)
         ACC_IDLE: begin
            if (s.mode[MODE_SLEEP_BIT]) begin
               next_s.cell_on = 1'b0; // [R24] [R26]
            end
            if ((sw_start || hw_start) && (s.chan_en != '0)) begin
               next_s.pending = s.chan_en;
               next_s.chan = first_channel(s.chan_en);
               next_s.count = '0;
               if (s.cell_on && !s.mode[MODE_SLEEP_BIT]) begin
                  next_s.state = ACC_SAMPLE;
               end else begin
                  next_s.cell_on = 1'b1; // [R24]
                  next_s.state = ACC_STARTUP; // [R7]
               end
            end
         end
         ACC_STARTUP: begin
            if (tick) begin
               if (s.count == startup_last - 1'b1) begin
                  next_s.count = '0;
                  next_s.state = ACC_SAMPLE; // [R7]
               end else begin
                  next_s.count = s.count + 1'b1;
               end
            end
         end
         ACC_SAMPLE: begin
            if (tick) begin
               if (s.count == COUNT_W'(s.mode[MODE_SAMPLE_HOLD_LSB +: SAMPLE_HOLD_W])) begin
                  next_s.count = '0;
                  next_s.start_pulse = 1'b1;
                  next_s.state = ACC_CONVERT; // [R8]
               end else begin
                  next_s.count = s.count + 1'b1;
               end
            end
         end
         ACC_CONVERT: begin
            // Starts arriving here are simply not looked at [R25]
            if (cell_done_in) begin
               if (s.mode[MODE_RESOLUTION_BIT]) begin
                  next_s.last_data = {2'b00, cell_data_in[RESULT_W-1:2]}; // [R26]
               end else begin
                  next_s.last_data = cell_data_in; // [R19]
               end
               next_s.res_data = next_s.last_data;
               next_s.res_chan = s.chan;
               next_s.res_valid = 1'b1;
               next_s.result_ready = 1'b1; // [R15]
               if (next_s.done[s.chan]) begin
                  next_s.overrun[s.chan] = 1'b1; // [R14]
                  next_s.global_overrun = 1'b1; // [R16]
               end
               next_s.done[s.chan] = 1'b1; // [R13]
               next_s.pending = remaining;
               if (remaining != '0) begin
                  next_s.chan = first_channel(remaining);
                  next_s.state = ACC_SAMPLE; // [R8]
               end else begin
                  next_s.cell_on = ~s.mode[MODE_SLEEP_BIT]; // [R24]
                  next_s.state = ACC_IDLE;
               end
            end
         end
         default: next_s.state = ACC_IDLE;
      endcase

      // Soft reset overrides everything else in the same cycle
      if (wr_done && paddr == OFS_CONVERTER_COMMAND && pwdata[CMD_SOFT_RESET_BIT]) begin
         next_s = REGS_RESET; // [R1]
         next_s.trig_prev = sel_trigger;
         next_s.rx_zero_prev = dma_rx_zero_in;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s <= REGS_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Zero wait states: read data was captured during setup
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = s.rdata;

   // Analog cell and result stream
   assign cell_power_out = s.cell_on;
   assign cell_sample_out = (s.state == ACC_SAMPLE);
   assign cell_start_out = s.start_pulse;
   assign cell_channel_out = s.chan;
   assign cell_low_res_out = s.mode[MODE_RESOLUTION_BIT];
   assign result_valid_out = s.res_valid;
   assign result_channel_out = s.res_chan;
   assign result_data_out = s.res_data;

   // Level interrupt; falls as soon as every enabled flag is clear
   assign irq_out = |(flags & s.irq_en); // [R27]

endmodule

// [logic/acc_pkg.sv]
package acc_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFS_CONVERTER_COMMAND = 8'h00;
   localparam logic [7:0] OFS_CONVERTER_MODE = 8'h04;
   localparam logic [7:0] OFS_CHANNEL_ENABLE_SET = 8'h10;
   localparam logic [7:0] OFS_CHANNEL_ENABLE_CLEAR = 8'h14;
   localparam logic [7:0] OFS_CHANNEL_ENABLED_STATE = 8'h18;
   localparam logic [7:0] OFS_CONVERTER_FLAGS = 8'h1C;
   localparam logic [7:0] OFS_LATEST_RESULT = 8'h20;
   localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h24;
   localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h28;
   localparam logic [7:0] OFS_IRQ_ENABLED_STATE = 8'h2C;

   // Command bits
   localparam int CMD_SOFT_RESET_BIT = 0;
   localparam int CMD_START_BIT = 1;

   // Mode register field positions
   localparam int MODE_HW_TRIGGER_ON_BIT = 0;
   localparam int MODE_TRIGGER_SOURCE_LSB = 1;
   localparam int MODE_RESOLUTION_BIT = 4;
   localparam int MODE_SLEEP_BIT = 5;
   localparam int MODE_CLOCK_DIVIDER_LSB = 8;
   localparam int MODE_STARTUP_LSB = 16;
   localparam int MODE_SAMPLE_HOLD_LSB = 24;
   localparam logic [31:0] MODE_WRITABLE_MASK = 32'h0F1F3F3F;
   localparam logic [31:0] MODE_RESET = 32'h00000000;

   // Field widths
   localparam int NUM_CH = 8;
   localparam int CH_IDX_W = 3;
   localparam int RESULT_W = 10;
   localparam int CLOCK_DIVIDER_W = 6;
   localparam int STARTUP_W = 5;
   localparam int SAMPLE_HOLD_W = 4;
   localparam int COUNT_W = 9;
   localparam int FLAG_W = 20;

   // Flag register bit positions
   localparam int FLAG_OVERRUN_LSB = 8;
   localparam int FLAG_RESULT_READY_BIT = 16;
   localparam int FLAG_GLOBAL_OVERRUN_BIT = 17;
   localparam int FLAG_RECEIVE_END_BIT = 18;
   localparam int FLAG_RECEIVE_FULL_BIT = 19;
   localparam logic [31:0] FLAGS_RESET = 32'h000C0000;

   // Trigger source codes
   localparam logic [2:0] TRIG_TIMER0_A = 3'h0;
   localparam logic [2:0] TRIG_TIMER1_A = 3'h1;
   localparam logic [2:0] TRIG_EXTERNAL = 3'h6;

   // Startup interval unit in converter clock periods
   localparam int STARTUP_PERIODS_PER_UNIT = 8;
   localparam int STARTUP_UNIT_SHIFT = 3;

   // Reset values of channel and interrupt enables
   localparam logic [7:0] CHAN_ENABLE_RESET = 8'h00;
   localparam logic [19:0] IRQ_ENABLE_RESET = 20'h00000;

   // Sequencer states
   typedef enum logic [3:0] {
      ACC_IDLE = 4'h1,
      ACC_STARTUP = 4'h2,
      ACC_SAMPLE = 4'h4,
      ACC_CONVERT = 4'h8
   } acc_state_e;

endpackage
